//--- common/psr_pkg.sv
// Purpose: constants for the peripheral soft reset control block
// Assumes: 32-bit register port, byte offsets
// Notes: capability masks arrive as inputs from the capability registers
package psr_pkg;
	// data and address widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;

	// register offsets
	localparam logic [11:0] OFF_CTRL_A = 12'h0040;
	localparam logic [11:0] OFF_CTRL_B = 12'h0044;
	localparam logic [11:0] OFF_CAP_A = 12'h0008;
	localparam logic [11:0] OFF_CAP_B = 12'h000C;
	localparam logic [11:0] OFF_IGN_A = 12'h0050;
	localparam logic [11:0] OFF_IGN_B = 12'h0054;

	// reset values
	localparam logic [31:0] RST_CTRL_A = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL_B = 32'h0000_0000;
	localparam logic [31:0] RST_IGN = 32'h0000_0000;
	localparam logic [31:0] RD_IDLE = 32'h0000_0000;

	// writable bits of each control register
	localparam logic [31:0] WR_MASK_A = 32'h0000_0048;
	localparam logic [31:0] WR_MASK_B = 32'h030F_5037;

	// bit positions, control register a
	localparam int BIT_HIB = 6;
	localparam int BIT_WDOG = 3;

	// bit positions, control register b
	localparam int BIT_CMP1 = 25;
	localparam int BIT_CMP0 = 24;
	localparam int BIT_TMR3 = 19;
	localparam int BIT_TMR2 = 18;
	localparam int BIT_TMR1 = 17;
	localparam int BIT_TMR0 = 16;
	localparam int BIT_TW1 = 14;
	localparam int BIT_TW0 = 12;
	localparam int BIT_SS1 = 5;
	localparam int BIT_SS0 = 4;
	localparam int BIT_AS2 = 2;
	localparam int BIT_AS1 = 1;
	localparam int BIT_AS0 = 0;
endpackage

//--- rtl/psr_ctrl_reg.sv
// Purpose: one masked software reset control register
// Assumes: capability mask is stable between writes
// Notes: absent or reserved bits hold zero
`timescale 1ns/10ps
module psr_ctrl_reg #(
	parameter logic [31:0] WR_MASK = 32'h0000_0000,
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// write side
	input wire logic wr_en_i,
	input wire logic [31:0] wr_data_i,
	// capability
	input wire logic [31:0] cap_i,
	// stored value
	output logic [31:0] q_o
);
	typedef struct packed {
		logic [31:0] ctrl;
	} psr_reg_state_t;

	psr_reg_state_t s_q;
	psr_reg_state_t s_d;
	logic [31:0] en;

	always_comb begin
		s_d = s_q;
		en = cap_i & WR_MASK;
		if (wr_en_i) begin
			s_d.ctrl = wr_data_i & en;
		end else begin
			s_d.ctrl = s_q.ctrl & en;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_q.ctrl <= RST_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.ctrl;
endmodule

//--- rtl/psr_top.sv
// Purpose: peripheral soft reset control, two masked control registers
// Assumes: register port strobes one cycle, synchronous to clk_sys_i
// Notes: every reset output is a flip-flop of a control register
// Behaviour
// - writes to register a masked by capability one, register b by two
// - register a bit 6 holds the hibernation module in reset
// - register a bit 3 holds the watchdog in reset
// - reserved bits read zero and ignore writes
// - register a at offset 0x040, resets to zero
// - register b at offset 0x044, resets to zero
// - register b bits 25 and 24 reset comparators one and zero
// - register b bits 19 to 16 reset timers three to zero
// - register b bit 14 resets two-wire one, bit 12 two-wire zero
// - register b bits 5 and 4 reset sync serial one and zero
// - register b bits 2, 1, 0 reset async serial two, one, zero
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module psr_top #(
	parameter int ADDR_W = psr_pkg::ADDR_W
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rd_data_o,
	// capability masks
	input wire logic [31:0] capability_mask_one_i,
	input wire logic [31:0] capability_mask_two_i,
	// system resets from register a
	output logic hibernation_reset_bit_o,
	output logic watchdog_reset_bit_o,
	// analog comparator resets
	output logic comparator_one_reset_bit_o,
	output logic comparator_zero_reset_bit_o,
	// timer resets
	output logic gp_timer_three_reset_bit_o,
	output logic gp_timer_two_reset_bit_o,
	output logic gp_timer_one_reset_bit_o,
	output logic gp_timer_zero_reset_bit_o,
	// two-wire resets
	output logic two_wire_one_reset_bit_o,
	output logic two_wire_zero_reset_bit_o,
	// sync serial resets
	output logic sync_serial_one_reset_bit_o,
	output logic sync_serial_zero_reset_bit_o,
	// async serial resets
	output logic async_serial_two_reset_bit_o,
	output logic async_serial_one_reset_bit_o,
	output logic async_serial_zero_reset_bit_o
);
	typedef struct packed {
		logic [31:0] rd_data;
		logic [31:0] ign_a;
		logic [31:0] ign_b;
	} psr_top_state_t;

	psr_top_state_t s_q;
	psr_top_state_t s_d;

	logic [31:0] ctrl_a;
	logic [31:0] ctrl_b;
	logic [11:0] addr_w;
	logic wr_a;
	logic wr_b;
	logic wr_ign_a;
	logic wr_ign_b;

	// address compare
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	// bits a write tried to set on absent peripherals
	function automatic logic [31:0] refused(
		input logic [31:0] data,
		input logic [31:0] wmask,
		input logic [31:0] cap
	);
		refused = data & wmask & ~cap;
	endfunction

	// sticky flag, set wins over clear
	function automatic logic [31:0] sticky(
		input logic [31:0] cur,
		input logic [31:0] set,
		input logic clr_en,
		input logic [31:0] clr
	);
		logic [31:0] kept;
		kept = clr_en ? (cur & ~clr) : cur;
		sticky = kept | set;
	endfunction

	// zero-extend or cut the port address to twelve bits
	always_comb begin
		addr_w = 12'h000;
		addr_w = 12'(addr_i);
	end

	assign wr_a = wr_i & hit(addr_w, psr_pkg::OFF_CTRL_A);
	assign wr_b = wr_i & hit(addr_w, psr_pkg::OFF_CTRL_B);
	assign wr_ign_a = wr_i & hit(addr_w, psr_pkg::OFF_IGN_A);
	assign wr_ign_b = wr_i & hit(addr_w, psr_pkg::OFF_IGN_B);

	psr_ctrl_reg #(
		.WR_MASK(psr_pkg::WR_MASK_A),
		.RST_VAL(psr_pkg::RST_CTRL_A)
	) u_ctrl_a (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.wr_en_i(wr_a),
		.wr_data_i(wr_data_i),
		.cap_i(capability_mask_one_i),
		.q_o(ctrl_a)
	);

	psr_ctrl_reg #(
		.WR_MASK(psr_pkg::WR_MASK_B),
		.RST_VAL(psr_pkg::RST_CTRL_B)
	) u_ctrl_b (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.wr_en_i(wr_b),
		.wr_data_i(wr_data_i),
		.cap_i(capability_mask_two_i),
		.q_o(ctrl_b)
	);

	always_comb begin
		s_d = s_q;

		s_d.ign_a = sticky(
			s_q.ign_a,
			wr_a ? refused(wr_data_i, psr_pkg::WR_MASK_A, capability_mask_one_i)
				: psr_pkg::RST_IGN,
			wr_ign_a,
			wr_data_i & psr_pkg::WR_MASK_A
		);

		s_d.ign_b = sticky(
			s_q.ign_b,
			wr_b ? refused(wr_data_i, psr_pkg::WR_MASK_B, capability_mask_two_i)
				: psr_pkg::RST_IGN,
			wr_ign_b,
			wr_data_i & psr_pkg::WR_MASK_B
		);

		// read data stand one cycle after the strobe
		s_d.rd_data = psr_pkg::RD_IDLE;
		if (rd_i) begin
			case (addr_w)
				// reserved bits of register a read zero
				psr_pkg::OFF_CTRL_A: begin
					s_d.rd_data = ctrl_a & psr_pkg::WR_MASK_A;
				end
				// reserved bits of register b read zero
				psr_pkg::OFF_CTRL_B: begin
					s_d.rd_data = ctrl_b & psr_pkg::WR_MASK_B;
				end
				psr_pkg::OFF_CAP_A: begin
					s_d.rd_data = capability_mask_one_i & psr_pkg::WR_MASK_A;
				end
				psr_pkg::OFF_CAP_B: begin
					s_d.rd_data = capability_mask_two_i & psr_pkg::WR_MASK_B;
				end
				psr_pkg::OFF_IGN_A: begin
					s_d.rd_data = s_q.ign_a;
				end
				psr_pkg::OFF_IGN_B: begin
					s_d.rd_data = s_q.ign_b;
				end
				// unmapped reads return zero
				default: begin
					s_d.rd_data = psr_pkg::RD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_q.rd_data <= psr_pkg::RD_IDLE;
			s_q.ign_a <= psr_pkg::RST_IGN;
			s_q.ign_b <= psr_pkg::RST_IGN;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_o = s_q.rd_data;

	assign hibernation_reset_bit_o = ctrl_a[psr_pkg::BIT_HIB];
	assign watchdog_reset_bit_o = ctrl_a[psr_pkg::BIT_WDOG];

	assign comparator_one_reset_bit_o = ctrl_b[psr_pkg::BIT_CMP1];
	assign comparator_zero_reset_bit_o = ctrl_b[psr_pkg::BIT_CMP0];

	assign gp_timer_three_reset_bit_o = ctrl_b[psr_pkg::BIT_TMR3];
	assign gp_timer_two_reset_bit_o = ctrl_b[psr_pkg::BIT_TMR2];
	assign gp_timer_one_reset_bit_o = ctrl_b[psr_pkg::BIT_TMR1];
	assign gp_timer_zero_reset_bit_o = ctrl_b[psr_pkg::BIT_TMR0];

	assign two_wire_one_reset_bit_o = ctrl_b[psr_pkg::BIT_TW1];
	assign two_wire_zero_reset_bit_o = ctrl_b[psr_pkg::BIT_TW0];

	assign sync_serial_one_reset_bit_o = ctrl_b[psr_pkg::BIT_SS1];
	assign sync_serial_zero_reset_bit_o = ctrl_b[psr_pkg::BIT_SS0];

	assign async_serial_two_reset_bit_o = ctrl_b[psr_pkg::BIT_AS2];
	assign async_serial_one_reset_bit_o = ctrl_b[psr_pkg::BIT_AS1];
	assign async_serial_zero_reset_bit_o = ctrl_b[psr_pkg::BIT_AS0];
endmodule

//--- sim/psr_chk.sv
// Purpose: port assertions for the soft reset control block
// Assumes: bound to psr_top, one clock domain
// Notes: read and write strobes never coincide
`timescale 1ns/10ps
module psr_chk #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rd_data_o,
	// capabilities and watched resets
	input wire logic [31:0] capability_mask_one_i,
	input wire logic [31:0] capability_mask_two_i,
	input wire logic hibernation_reset_bit_o,
	input wire logic watchdog_reset_bit_o,
	input wire logic async_serial_zero_reset_bit_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_wr_a;
		wr_i && addr_i == psr_pkg::OFF_CTRL_A;
	endsequence
	sequence s_wr_b;
		wr_i && addr_i == psr_pkg::OFF_CTRL_B;
	endsequence
	a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 32'h0000_0000)
		else $error("read data not zero outside read");
	a_hib_write: assert property (s_wr_a ##0 capability_mask_one_i[6] |=>
		hibernation_reset_bit_o == $past(wr_data_i[6])) else $error("hib bit write");
	a_wdog_write: assert property (s_wr_a ##0 capability_mask_one_i[3] |=>
		watchdog_reset_bit_o == $past(wr_data_i[3])) else $error("watchdog bit write");
	a_uart_write: assert property (s_wr_b |=> async_serial_zero_reset_bit_o ==
		$past(wr_data_i[0] & capability_mask_two_i[0])) else $error("async_serial_zero_reset_bit bit write");
	a_absent_reads_zero: assert property (!capability_mask_one_i[6] |=>
		!hibernation_reset_bit_o) else $error("absent hib bit set");
	a_hold_no_write: assert property (!wr_i && capability_mask_one_i[3] |=>
		$stable(watchdog_reset_bit_o)) else $error("watchdog bit moved");
	a_read_reg_a: assert property (rd_i && addr_i == psr_pkg::OFF_CTRL_A |=>
		rd_data_o == {25'h0, $past(hibernation_reset_bit_o), 2'h0,
		$past(watchdog_reset_bit_o), 3'h0}) else $error("read of register a");
	a_read_b_res: assert property (rd_i && addr_i == psr_pkg::OFF_CTRL_B |=>
		(rd_data_o & ~psr_pkg::WR_MASK_B) == 32'h0000_0000) else $error("reserved b bits");
endmodule

bind psr_top psr_chk #(.ADDR_W(ADDR_W)) i_psr_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
	.capability_mask_one_i(capability_mask_one_i),
	.capability_mask_two_i(capability_mask_two_i),
	.hibernation_reset_bit_o(hibernation_reset_bit_o),
	.watchdog_reset_bit_o(watchdog_reset_bit_o),
	.async_serial_zero_reset_bit_o(async_serial_zero_reset_bit_o));

//--- sim/tb_top.sv
// Purpose: self-checking bench for the soft reset control block
// Assumes: register port strobes one cycle, read data one cycle later
// Notes: reset outputs gathered into register-shaped words
`timescale 1ns/10ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [31:0] wr_data_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] capability_mask_one_i = 32'hFFFF_FFFF;
	logic [31:0] capability_mask_two_i = 32'hFFFF_FFFF;
	logic [31:0] rd_data_o;
	logic hibernation_reset_bit, wdog, c1, c0, t3, t2, t1, t0, w1, w0, s1, s0, u2, u1, u0;
	logic [31:0] out_a, out_b;
	int mismatches = 0;
	int total_checks = 0;
	assign out_a = {25'h0, hibernation_reset_bit, 2'h0, wdog, 3'h0};
	assign out_b = {6'h0, c1, c0, 4'h0, t3, t2, t1, t0, 1'b0, w1, 1'b0, w0, 6'h0, s1, s0,
		1'b0, u2, u1, u0};
	always #2 clk_sys_i = ~clk_sys_i;
	psr_top i_psr_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.capability_mask_one_i(capability_mask_one_i),
		.capability_mask_two_i(capability_mask_two_i), .hibernation_reset_bit_o(hibernation_reset_bit),
		.watchdog_reset_bit_o(wdog), .comparator_one_reset_bit_o(c1),
		.comparator_zero_reset_bit_o(c0), .gp_timer_three_reset_bit_o(t3),
		.gp_timer_two_reset_bit_o(t2), .gp_timer_one_reset_bit_o(t1),
		.gp_timer_zero_reset_bit_o(t0), .two_wire_one_reset_bit_o(w1),
		.two_wire_zero_reset_bit_o(w0), .sync_serial_one_reset_bit_o(s1),
		.sync_serial_zero_reset_bit_o(s0), .async_serial_two_reset_bit_o(u2),
		.async_serial_one_reset_bit_o(u1), .async_serial_zero_reset_bit_o(u0));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		chk(rd_data_o, exp);
	endtask
	task automatic t_reset();
		rd(12'h040, 32'h0000_0000);
		rd(12'h044, 32'h0000_0000);
		chk(out_a | out_b, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_reg_a();
		wr(12'h040, 32'hFFFF_FFFF);
		chk(out_a, 32'h0000_0048);
		rd(12'h040, 32'h0000_0048);
		wr(12'h040, 32'h0000_0008);
		chk(out_a, 32'h0000_0008);
		wr(12'h040, 32'h0000_0000);
		chk(out_a, 32'h0000_0000);
		$display("test register a done");
	endtask
	task automatic t_map_b();
		for (int i = 0; i < 32; i++) begin
			wr(12'h044, 32'h0000_0001 << i);
			chk(out_b, (32'h0000_0001 << i) & 32'h030F_5037);
		end
		wr(12'h044, 32'hFFFF_FFFF);
		chk(out_b, 32'h030F_5037);
		chk({30'h0, c1, c0}, 32'h0000_0003);
		chk({28'h0, t3, t2, t1, t0}, 32'h0000_000F);
		chk({30'h0, w1, w0}, 32'h0000_0003);
		chk({30'h0, s1, s0}, 32'h0000_0003);
		chk({29'h0, u2, u1, u0}, 32'h0000_0007);
		rd(12'h044, 32'h030F_5037);
		wr(12'h044, 32'h0000_0000);
		$display("test register b map done");
	endtask
	task automatic t_mid_reset();
		wr(12'h044, 32'h0000_0007);
		chk(out_b, 32'h0000_0007);
		wr(12'h040, 32'h0000_0048);
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		chk(out_a | out_b, 32'h0000_0000);
		rd(12'h040, 32'h0000_0000);
		rd(12'h044, 32'h0000_0000);
		$display("test mid reset done");
	endtask
	task automatic t_cap();
		@(posedge clk_sys_i);
		capability_mask_two_i <= 32'h0000_1011;
		wr(12'h044, 32'hFFFF_FFFF);
		chk(out_b, 32'h0000_1011);
		rd(12'h044, 32'h0000_1011);
		rd(12'h00C, 32'h0000_1011);
		rd(12'h054, 32'h030F_4026);
		wr(12'h054, 32'hFFFF_FFFF);
		rd(12'h054, 32'h0000_0000);
		wr(12'h040, 32'h0000_0048);
		@(posedge clk_sys_i);
		capability_mask_one_i <= 32'h0000_0008;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(out_a, 32'h0000_0008);
		wr(12'h040, 32'h0000_0048);
		chk(out_a, 32'h0000_0008);
		rd(12'h050, 32'h0000_0040);
		rd(12'h008, 32'h0000_0008);
		rd(12'h048, 32'h0000_0000);
		$display("test capability done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_reset();
		t_reg_a();
		t_map_b();
		t_mid_reset();
		t_cap();
		close_out();
	end
endmodule
